// ==== rtl/sbd_engine.sv ====
// Purpose: APB-controlled descriptor engine: load, issue, write back results
// Assumes: Link reports each transaction outcome as a one-cycle response
// Notes:   Descriptor words live in a small memory; DW3 is written back
`timescale 1ns/1ns
module sbd_engine
  import sbd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link request and response
  output sbd_req_t         link_req,
  input  wire sbd_resp_t   link_resp,
  // Interrupt
  output logic             irq
);

  typedef enum logic [2:0] {
    SBD_IDLE, SBD_RD0, SBD_RD1, SBD_RD2, SBD_RD3, SBD_ISSUE, SBD_WAIT, SBD_WB
  } sbd_state_t;

  sbd_state_t  state_reg, state_next;
  logic [63:0] dw_reg [3];
  logic [63:0] dw3_reg, dw3_next;
  logic [31:0] stage_reg;
  logic [1:0]  mem_idx_reg;
  logic        go_reg;
  logic [SBD_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
  sbd_result_t last_res_reg;
  sbd_req_t    link_req_next;
  logic        busy;

  // APB decode; the answer is registered in the setup cycle, so every
  // transfer completes in its first access cycle and writes land there.
  // Writes are not qualified by pready because pready is always high
  // in the access cycle of this slave.
  wire logic apb_acc = psel && penable;
  wire logic apb_wr  = apb_acc && pwrite;
  wire logic apb_rd  = apb_acc && !pwrite;
  wire logic hit_ctrl = (paddr == SBD_CTRL_OFF);
  wire logic hit_lo   = (paddr == SBD_MEM_LO_OFF);
  wire logic hit_hi   = (paddr == SBD_MEM_HI_OFF);
  wire logic hit_idx  = (paddr == SBD_MEM_IDX_OFF);
  wire logic hit_clr  = (paddr == SBD_IRQ_CLR_OFF);
  wire logic hit_en   = (paddr == SBD_IRQ_EN_OFF);
  wire logic mapped   = hit_ctrl || hit_lo || hit_hi || hit_idx || hit_clr || hit_en ||
                        (paddr == SBD_STATUS_OFF) || (paddr == SBD_IRQ_STAT_OFF) ||
                        (paddr == SBD_RESULT_OFF) || (paddr == SBD_TOKEN_OFF) ||
                        (paddr == SBD_SLOT_OFF);

  // Memory ports: software writes the staged word when it writes the high half
  wire logic                  sw_mem_wr = apb_wr && hit_hi && !busy;
  wire logic                  hw_mem_wr = (state_reg == SBD_WB);
  wire logic                  mem_wr    = sw_mem_wr || hw_mem_wr;
  wire logic [SBD_MEM_AW-1:0] mem_waddr = hw_mem_wr ? SBD_DW3 : mem_idx_reg;
  wire logic [63:0]           mem_wdata = hw_mem_wr ? dw3_reg : {pwdata, stage_reg[31:0]};
  logic      [SBD_MEM_AW-1:0] mem_raddr;
  logic      [63:0]           mem_rdata;

  sbd_desc_mem u_mem (
    .pclk    (pclk),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  sbd_desc_t dec_desc;
  logic      dec_kind_ok, dec_token_ok, dec_sq_used;

  sbd_field_decode u_dec (
    .dw0      (dw_reg[0]),
    .dw1      (dw_reg[1]),
    .dw2      (dw_reg[2]),
    .desc     (dec_desc),
    .kind_ok  (dec_kind_ok),
    .token_ok (dec_token_ok),
    .sq_used  (dec_sq_used)
  );

  // Write-back field views of DW3; the retry decisions below look at the
  // counters as they stand before this response, so a counter of one that
  // is decremented by this response is the one that retires the descriptor.
  // Write-back field views of DW3
  wire logic       active    = dw3_reg[SBD_ACTIVE_BIT];
  wire logic [3:0] nak_cnt   = dw3_reg[SBD_NAK_LSB +: 4];
  wire logic [1:0] cerr_cnt  = dw3_reg[SBD_CERR_LSB +: 2];
  wire logic [3:0] reload    = dec_desc.retry_reload;
  wire logic       rsp       = (state_reg == SBD_WAIT) && link_resp.valid;
  wire logic       rsp_ack   = rsp && (link_resp.result == SBD_RES_ACK);
  wire logic       rsp_nak   = rsp && (link_resp.result == SBD_RES_NAK);
  wire logic       rsp_nyet  = rsp && (link_resp.result == SBD_RES_NYET);
  wire logic       rsp_err   = rsp && ((link_resp.result == SBD_RES_NORESP) ||
                                       (link_resp.result == SBD_RES_BAD));
  wire logic       rsp_stall = rsp && (link_resp.result == SBD_RES_STALL);
  wire logic       nak_out   = rsp_nak && (reload != 4'h0) && (nak_cnt == 4'h1);
  wire logic       err_out   = rsp_err && (cerr_cnt <= 2'h1);
  wire logic       fatal     = nak_out || err_out || rsp_stall;
  wire logic [14:0] new_count = dw3_reg[SBD_DONE_LSB +: 15] + link_resp.count;
  wire logic       all_done  = rsp_ack && (new_count >= dec_desc.transfer_length);

  assign busy = (state_reg != SBD_IDLE);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    mem_raddr  = SBD_DW0;
    case (state_reg)
      SBD_IDLE: begin
        if (go_reg) begin
          state_next = SBD_RD0;
        end
      end
      SBD_RD0: begin
        mem_raddr  = SBD_DW1;
        state_next = SBD_RD1;
      end
      SBD_RD1: begin
        mem_raddr  = SBD_DW2;
        state_next = SBD_RD2;
      end
      SBD_RD2: begin
        mem_raddr  = SBD_DW3;
        state_next = SBD_RD3;
      end
      SBD_RD3: begin
        state_next = mem_rdata[SBD_ACTIVE_BIT] ? SBD_ISSUE : SBD_IDLE;
      end
      SBD_ISSUE: begin
        state_next = (dec_kind_ok && dec_token_ok) ? SBD_WAIT : SBD_WB;
      end
      SBD_WAIT: begin
        if (rsp) begin
          state_next = SBD_WB;
        end
      end
      default: begin
        state_next = (active && !rsp) ? SBD_ISSUE : SBD_IDLE;
      end
    endcase
  end

  // DW3 update from the link outcome
  always_comb begin
    dw3_next = dw3_reg;
    if (state_reg == SBD_RD3) begin
      dw3_next = mem_rdata;
    end else if (state_reg == SBD_ISSUE && !(dec_kind_ok && dec_token_ok)) begin
      dw3_next[SBD_ACTIVE_BIT] = 1'b0;
    end else if (rsp) begin
      if (rsp_ack) begin
        dw3_next[SBD_DONE_LSB +: 15] = new_count;
      end
      if (rsp_nak && reload != 4'h0) begin
        dw3_next[SBD_NAK_LSB +: 4] = nak_cnt - 4'h1;
      end
      if (rsp_nak || rsp_nyet) begin
        dw3_next[SBD_CERR_LSB +: 2] = SBD_CERR_MAX;
      end
      if (rsp_err && cerr_cnt != 2'h0) begin
        dw3_next[SBD_CERR_LSB +: 2] = cerr_cnt - 2'h1;
      end
      if (all_done || fatal) begin
        dw3_next[SBD_ACTIVE_BIT] = 1'b0;
      end
    end
  end

  // Request presented to the link
  always_comb begin
    link_req_next          = '0;
    link_req_next.start    = (state_reg == SBD_ISSUE) && dec_kind_ok && dec_token_ok;
    link_req_next.desc     = dec_desc;
    link_req_next.kind_ok  = dec_kind_ok;
    link_req_next.token_ok = dec_token_ok;
    link_req_next.sq_used  = dec_sq_used;
  end

  // Interrupt events: done, fatal, nak exhaust, bad response
  assign irq_set = {rsp_err, nak_out, fatal, all_done};

  // Sequencer and descriptor registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= SBD_IDLE;
      dw3_reg      <= '0;
      dw_reg[0]    <= '0;
      dw_reg[1]    <= '0;
      dw_reg[2]    <= '0;
      last_res_reg <= SBD_RES_ACK;
      link_req     <= '0;
    end else begin
      state_reg <= state_next;
      dw3_reg   <= dw3_next;
      link_req  <= link_req_next;
      if (state_reg == SBD_RD0) dw_reg[0] <= mem_rdata;
      if (state_reg == SBD_RD1) dw_reg[1] <= mem_rdata;
      if (state_reg == SBD_RD2) dw_reg[2] <= mem_rdata;
      if (rsp) last_res_reg <= link_resp.result;
    end
  end

  // Software-side registers; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_reg       <= 1'b0;
      stage_reg    <= '0;
      mem_idx_reg  <= '0;
      irq_en_reg   <= '0;
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      go_reg       <= (apb_wr && hit_ctrl && !busy) ? pwdata[0] : (go_reg && !busy);
      irq_stat_reg <= (irq_stat_reg & ~((apb_wr && hit_clr) ? pwdata[SBD_IRQ_W-1:0]
                                                          : '0)) | irq_set;
      irq          <= |(irq_stat_reg & irq_en_reg);
      if (apb_wr && hit_lo) stage_reg[31:0] <= pwdata;
      if (apb_wr && hit_idx) mem_idx_reg <= pwdata[1:0];
      if (apb_wr && hit_en) irq_en_reg <= pwdata[SBD_IRQ_W-1:0];
    end
  end

  // APB read data and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        if (paddr == SBD_STATUS_OFF) begin
          prdata <= {27'h0, active, busy, last_res_reg};
        end else if (paddr == SBD_IRQ_STAT_OFF) begin
          prdata <= {28'h0, irq_stat_reg};
        end else if (paddr == SBD_IRQ_EN_OFF) begin
          prdata <= {28'h0, irq_en_reg};
        end else if (paddr == SBD_RESULT_OFF) begin
          prdata <= dw3_reg[63:32];
        end else if (paddr == SBD_TOKEN_OFF) begin
          prdata <= {14'h0, dec_desc.function_addr, dec_desc.endpoint_num, dec_desc.token,
                     dec_desc.endpoint_kind, dec_desc.split, dec_desc.speed_qualifier};
        end else if (paddr == SBD_SLOT_OFF) begin
          prdata <= {dw3_reg[31:0]};
        end else if (paddr == SBD_MEM_IDX_OFF) begin
          prdata <= {30'h0, mem_idx_reg};
        end else if (paddr == SBD_CTRL_OFF) begin
          prdata <= {31'h0, go_reg};
        end
      end
    end
  end

  wire logic unused_rd = apb_rd;

endmodule

// ==== common/sbd_pkg.sv ====
// Purpose: Shared constants and types for the split bulk descriptor engine
// Assumes: Descriptor of four 64-bit words; word index 0..3 in descriptor memory
// Notes:   Bit positions count within one 64-bit descriptor word
// Operation
// - write back actual transferred byte count
// - reload zero disables the NAK retry counter
// - buffer start is internal memory address
// - speed qualifier used only for splits
// - split bit selects high-speed or split
// - decode endpoint kind and token codes
// - tokens use the function address field
// - endpoint number spans two descriptor words
// - max packet size limits packet bytes
// - transfer length bounds the payload size
// - active bit cleared on completion or fatal
// - NAK counter reaching zero retires descriptor
// - error counter decrements, retires, reloads
package sbd_pkg;

  // APB register byte offsets
  localparam logic [7:0] SBD_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SBD_STATUS_OFF = 8'h04;
  localparam logic [7:0] SBD_IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] SBD_IRQ_EN_OFF = 8'h0c;
  localparam logic [7:0] SBD_IRQ_CLR_OFF = 8'h10;
  localparam logic [7:0] SBD_RESULT_OFF = 8'h14;
  localparam logic [7:0] SBD_TOKEN_OFF  = 8'h18;
  localparam logic [7:0] SBD_SLOT_OFF   = 8'h1c;
  localparam logic [7:0] SBD_MEM_LO_OFF = 8'h40;
  localparam logic [7:0] SBD_MEM_HI_OFF = 8'h44;
  localparam logic [7:0] SBD_MEM_IDX_OFF = 8'h48;

  // Descriptor memory geometry
  localparam int          SBD_MEM_DEPTH = 4;
  localparam int          SBD_MEM_AW    = 2;
  localparam logic [1:0]  SBD_DW0 = 2'h0;
  localparam logic [1:0]  SBD_DW1 = 2'h1;
  localparam logic [1:0]  SBD_DW2 = 2'h2;
  localparam logic [1:0]  SBD_DW3 = 2'h3;

  // Field positions (within 64-bit word)
  localparam int SBD_ACTIVE_BIT   = 0;
  localparam int SBD_LEN_LSB      = 3;
  localparam int SBD_MPS_LSB      = 18;
  localparam int SBD_EP0_BIT      = 31;
  localparam int SBD_EPH_LSB      = 32;
  localparam int SBD_FADDR_LSB    = 35;
  localparam int SBD_TOKEN_LSB    = 42;
  localparam int SBD_KIND_LSB     = 44;
  localparam int SBD_SPLIT_BIT    = 46;
  localparam int SBD_SQ_LSB       = 48;
  localparam int SBD_PORT_LSB     = 50;
  localparam int SBD_HUB_LSB      = 57;
  localparam int SBD_BUF_LSB      = 8;
  localparam int SBD_RL_LSB       = 25;
  localparam int SBD_DONE_LSB     = 32;
  localparam int SBD_NAK_LSB      = 51;
  localparam int SBD_CERR_LSB     = 55;

  // Address translation
  localparam logic [18:0] SBD_CPU_BASE  = 19'h00400;
  localparam int          SBD_ADDR_SHIFT = 3;

  // Encodings
  localparam logic [1:0] SBD_KIND_CTRL = 2'h0;
  localparam logic [1:0] SBD_KIND_BULK = 2'h2;
  localparam logic [1:0] SBD_TOK_OUT   = 2'h0;
  localparam logic [1:0] SBD_TOK_IN    = 2'h1;
  localparam logic [1:0] SBD_TOK_SETUP = 2'h2;
  localparam logic [1:0] SBD_CERR_MAX  = 2'h3;

  // Interrupt bits
  localparam int SBD_IRQ_DONE  = 0;
  localparam int SBD_IRQ_FATAL = 1;
  localparam int SBD_IRQ_NAK   = 2;
  localparam int SBD_IRQ_BAD   = 3;
  localparam int SBD_IRQ_W     = 4;

  // Bus outcome reported by the link
  typedef enum logic [2:0] {
    SBD_RES_ACK, SBD_RES_NAK, SBD_RES_NYET, SBD_RES_NORESP, SBD_RES_BAD, SBD_RES_STALL
  } sbd_result_t;

  // Decoded descriptor
  typedef struct packed {
    logic [6:0]  hub_addr;
    logic [6:0]  hub_port;
    logic [1:0]  speed_qualifier;
    logic        split;
    logic [1:0]  endpoint_kind;
    logic [1:0]  token;
    logic [6:0]  function_addr;
    logic [3:0]  endpoint_num;
    logic [10:0] max_packet_size;
    logic [14:0] transfer_length;
    logic [15:0] buffer_start;
    logic [3:0]  retry_reload;
  } sbd_desc_t;

  // Transaction request toward the link
  typedef struct packed {
    logic        start;
    sbd_desc_t   desc;
    logic        kind_ok;
    logic        token_ok;
    logic        sq_used;
  } sbd_req_t;

  // Completion report from the link
  typedef struct packed {
    logic        valid;
    sbd_result_t result;
    logic [14:0] count;
  } sbd_resp_t;

endpackage

// ==== rtl/sbd_desc_mem.sv ====
// Purpose: Four-word, 64-bit descriptor store with registered read
// Assumes: One write port and one read port, both on pclk
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ns
module sbd_desc_mem
  import sbd_pkg::*;
(
  // Clock
  input  wire logic                  pclk,
  // Write side
  input  wire logic                  wr_en,
  input  wire logic [SBD_MEM_AW-1:0] wr_addr,
  input  wire logic [63:0]           wr_data,
  // Read side
  input  wire logic [SBD_MEM_AW-1:0] rd_addr,
  output logic      [63:0]           rd_data
);

  logic [63:0] mem_reg [SBD_MEM_DEPTH];

  // Storage and registered read
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule

// ==== rtl/sbd_field_decode.sv ====
// Purpose: Unpack descriptor words into fields and check encodings
// Assumes: Words held stable by the caller
// Notes:   Purely combinational; reserved bits are never looked at
`timescale 1ns/1ns
module sbd_field_decode
  import sbd_pkg::*;
(
  // Descriptor words
  input  wire logic [63:0] dw0,
  input  wire logic [63:0] dw1,
  input  wire logic [63:0] dw2,
  // Decoded view
  output sbd_desc_t        desc,
  output logic             kind_ok,
  output logic             token_ok,
  output logic             sq_used
);

  // Field extraction; reserved positions are skipped
  assign desc.hub_addr        = dw1[SBD_HUB_LSB +: 7];
  assign desc.hub_port        = dw1[SBD_PORT_LSB +: 7];
  assign desc.split           = dw1[SBD_SPLIT_BIT];
  assign desc.speed_qualifier = desc.split ? dw1[SBD_SQ_LSB +: 2] : 2'h0;
  assign desc.endpoint_kind   = dw1[SBD_KIND_LSB +: 2];
  assign desc.token           = dw1[SBD_TOKEN_LSB +: 2];
  assign desc.function_addr   = dw1[SBD_FADDR_LSB +: 7];
  assign desc.endpoint_num    = {dw1[SBD_EPH_LSB +: 3], dw0[SBD_EP0_BIT]};
  assign desc.max_packet_size = dw0[SBD_MPS_LSB +: 11];
  assign desc.transfer_length = dw0[SBD_LEN_LSB +: 15];
  assign desc.buffer_start    = dw2[SBD_BUF_LSB +: 16];
  assign desc.retry_reload    = dw2[SBD_RL_LSB +: 4];

  // Encoding checks
  assign kind_ok  = (desc.endpoint_kind == SBD_KIND_CTRL) ||
                    (desc.endpoint_kind == SBD_KIND_BULK);
  assign token_ok = (desc.token == SBD_TOK_OUT) || (desc.token == SBD_TOK_IN) ||
                    (desc.token == SBD_TOK_SETUP);
  assign sq_used  = desc.split;

endmodule

// ==== tb/sbd_engine_props.sv ====
// Purpose: Port-level checks on the descriptor engine
// Assumes: Descriptor words are loaded only while the engine is idle
// Notes:   A shadow of the loaded words gives the expected request fields
`timescale 1ns/1ns
module sbd_engine_props
  import sbd_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link and interrupt
  input wire sbd_req_t    link_req,
  input wire sbd_resp_t   link_resp,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [63:0] w [4];
  logic [31:0] lo;
  logic [1:0]  ix;
  sbd_desc_t   d;
  wire         wr = psel && penable && pready && pwrite;
  wire         st = link_req.start;
  assign d = link_req.desc;
  // Shadow of the descriptor words as software loads them
  always_ff @(posedge pclk) begin
    if (wr && paddr == SBD_MEM_IDX_OFF) ix <= pwdata[1:0];
    if (wr && paddr == SBD_MEM_LO_OFF) lo <= pwdata;
    if (wr && paddr == SBD_MEM_HI_OFF) w[ix] <= {pwdata, lo};
  end
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_kind_code: assert property (st |-> link_req.kind_ok &&
    (d.endpoint_kind == SBD_KIND_CTRL || d.endpoint_kind == SBD_KIND_BULK))
    else $error("request issued with bad endpoint kind");
  a_token_code: assert property (st |-> link_req.token_ok && d.token != 2'h3)
    else $error("request issued with bad token");
  a_split_sel: assert property (st |-> d.split == w[1][46] &&
    link_req.sq_used == d.split &&
    d.speed_qualifier == (d.split ? w[1][49:48] : 2'h0))
    else $error("split or qualifier mismatch");
  a_func_addr: assert property (st |-> d.function_addr == w[1][41:35] &&
    d.endpoint_num == {w[1][34:32], w[0][31]})
    else $error("function or endpoint mismatch");
  a_buf_field: assert property (st |-> d.buffer_start == w[2][23:8] &&
    d.retry_reload == w[2][28:25] && d.hub_addr == w[1][63:57])
    else $error("buffer, reload or hub mismatch");
  a_size_fields: assert property (st |-> d.max_packet_size == w[0][28:18] &&
    d.transfer_length == w[0][17:3])
    else $error("size fields mismatch");
  a_one_flight: assert property (st |=> !st [*3])
    else $error("request reissued too soon");
  a_wb_gap: assert property (link_resp.valid |-> !st ##1 !st)
    else $error("request before write back");
  cover property (st && d.split);
  cover property (link_resp.valid && link_resp.result == SBD_RES_NAK);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule
bind sbd_engine sbd_engine_props sbd_engine_props_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_req, .link_resp, .irq);

// ==== tb/sbd_link_model.sv ====
// Purpose: Far-side model: hub translator and target function
// Assumes: The bench plans one outcome per issued request
// Notes:   Unplanned requests get an empty ACK; count idles inverted
`timescale 1ns/1ns
module sbd_link_model
  import sbd_pkg::*;
(
  // Clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // Request in, outcome out
  input wire sbd_req_t link_req,
  output sbd_resp_t    link_resp
);
  sbd_result_t q_r [$];
  logic [14:0] q_c [$];
  int          q_d [$];
  int          dly;
  // Bench plans the next outcome and its latency
  task automatic plan(input sbd_result_t r, input logic [14:0] c, input int d);
    q_r.push_back(r);
    q_c.push_back(c);
    q_d.push_back(d);
  endtask
  // Answer each request after the planned delay, one-cycle pulse
  initial begin
    link_resp = '0;
    forever begin
      @(posedge pclk);
      if (presetn && link_req.start === 1'b1) begin
        dly = (q_d.size() > 0) ? q_d.pop_front() : 1;
        repeat (dly) @(posedge pclk);
        link_resp.result <= (q_r.size() > 0) ? q_r.pop_front() : SBD_RES_ACK;
        link_resp.count <= (q_c.size() > 0) ? q_c.pop_front() : 15'h0;
        link_resp.valid <= 1'b1;
        @(posedge pclk);
        link_resp.valid <= 1'b0;
        link_resp.count <= ~link_resp.count;
      end
    end
  end
endmodule

// ==== tb/sbd_engine_test.sv ====
// Purpose: Self-checking bench for the descriptor engine
// Assumes: Zero-wait APB slave; link model on the far side
// Notes:   Table rows cover codes, retries, errors and a refusal
`timescale 1ns/1ns
module sbd_engine_test
  import sbd_pkg::*;
;
  localparam int NR = 6;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  sbd_req_t    link_req;
  sbd_resp_t   link_resp;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [31:0] lfsr = 32'haa19;
  logic [32:0] q_e [$];
  logic [32:0] q_m [$];
  sbd_req_t    q_d [$];
  // Row table: kind, token, split, qualifier, reload, error count, outcomes
  logic [1:0]  kd_t [NR] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1};
  logic [1:0]  tk_t [NR] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0};
  logic        sp_t [NR] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [1:0]  sq_t [NR] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
  logic [3:0]  rl_t [NR] = '{4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
  logic [1:0]  ce_t [NR] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h3};
  logic [3:0]  st_t [NR] = '{4'h1, 4'h9, 4'h6, 4'ha, 4'h2, 4'h0};
  int          nr_t [NR] = '{1, 4, 2, 5, 1, 0};
  int          rs_t [NR][5] = '{'{0, 0, 0, 0, 0}, '{3, 1, 3, 0, 0}, '{1, 1, 0, 0, 0},
                                '{3, 2, 4, 3, 3}, '{5, 0, 0, 0, 0}, '{0, 0, 0, 0, 0}};
  logic [31:0] rm_t [NR] = '{32'h7fff, 32'h78_7fff, 32'h78_0000, 32'h180_0000, 32'h0, 32'h0};

  always #10 pclk = ~pclk;

  sbd_engine sbd_engine_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link_req, .link_resp, .irq);
  sbd_link_model sbd_link_model_inst (.pclk, .presetn, .link_req, .link_resp);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp_val(input string what, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_req(input sbd_req_t e, input sbd_req_t g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR link_req expected %h seen %h", e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      $display("ERROR timeout expected finish seen hang");
      conclude();
    end
  end

  // Watcher: each read answer and each link request against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_e.size() > 0)
      cmp_val("read", q_e.pop_front(), {pslverr, prdata} & q_m.pop_front());
    if (link_req.start === 1'b1) begin
      if (q_d.size() > 0) cmp_req(q_d.pop_front(), link_req);
      else cmp_val("extra start", 33'h0, 33'h1);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    q_e.push_back(e & m);
    q_m.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic put(input logic [1:0] i, input logic [63:0] v);
    apb(1'b1, SBD_MEM_IDX_OFF, {30'h0, i});
    apb(1'b1, SBD_MEM_LO_OFF, v[31:0]);
    apb(1'b1, SBD_MEM_HI_OFF, v[63:32]);
  endtask

  task automatic wait_irq(input logic e, input int lim);
    int k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
    cmp_val("irq", {32'h0, e}, {32'h0, irq});
  endtask

  task automatic run_row(input int r);
    logic [31:0] a;
    logic [31:0] b;
    logic [14:0] len;
    logic [10:0] mps;
    sbd_desc_t   d;
    lfsr = lfsr_next(lfsr);
    a = lfsr;
    lfsr = lfsr_next(lfsr);
    b = lfsr;
    len = b[30:16] | 15'h1;
    mps = {5'h0, a[30:25]} + 11'h1;
    d = '{a[6:0], a[13:7], sq_t[r], sp_t[r], kd_t[r], tk_t[r], a[20:14], a[24:21],
          mps, len, b[15:0], rl_t[r]};
    put(2'h0, {32'h0, a[21], 2'h0, mps, len, 3'h1});
    put(2'h1, {a[6:0], a[13:7], sq_t[r], 1'b0, sp_t[r], kd_t[r], tk_t[r], a[20:14],
               a[24:22], 32'h0});
    put(2'h2, {35'h0, rl_t[r], 1'b0, b[15:0], 8'h0});
    put(2'h3, {7'h0, ce_t[r], rl_t[r], 19'h0, 31'h0, 1'b1});
    for (int i = 0; i < nr_t[r]; i++) begin
      sbd_link_model_inst.plan(sbd_result_t'(rs_t[r][i]), (rs_t[r][i] == 0) ? len : 15'h0,
                               1 + 6 * (i % 2));
      q_d.push_back('{1'b1, d, 1'b1, 1'b1, sp_t[r]});
    end
    apb(1'b1, SBD_IRQ_EN_OFF, (r == 0) ? 32'h1 : 32'h3);
    apb(1'b1, SBD_CTRL_OFF, 32'h1);
    wait_irq(nr_t[r] != 0, (nr_t[r] != 0) ? 2000 : 40);
    rd(SBD_RESULT_OFF, {18'h0, len}, {1'b1, rm_t[r]});
    rd(SBD_SLOT_OFF, 33'h0, 33'h1_0000_0001);
    rd(SBD_STATUS_OFF, 33'h0, 33'h1_0000_0018);
    rd(SBD_TOKEN_OFF, {15'h0, a[20:14], a[24:21], tk_t[r], kd_t[r], sp_t[r], sq_t[r]},
       {33{1'b1}});
    rd(SBD_IRQ_STAT_OFF, {29'h0, st_t[r]}, 33'h1_0000_000f);
    if (r == 0) begin
      apb(1'b1, SBD_IRQ_EN_OFF, 32'h0);
      @(posedge pclk);
      cmp_val("irq masked", 33'h0, {32'h0, irq});
    end
    apb(1'b1, SBD_IRQ_CLR_OFF, 32'hf);
    rd(SBD_IRQ_STAT_OFF, 33'h0, 33'h1_0000_000f);
    $display("row %0d done", r);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h80, {1'b1, 32'h0}, {33{1'b1}});
    for (int r = 0; r < NR; r++) run_row(r);
    cmp_val("starts left", 33'h0, 33'(q_d.size()));
    conclude();
  end
endmodule
